// ==== hw/psc_ctrl.sv ====
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_ctrl #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Byte register port behind the main serial interface
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [ADDR_W-1:0]       reg_addr,
    input  wire logic [DATA_W-1:0]       reg_wdata,
    output logic      [DATA_W-1:0]       reg_rdata,
    output logic                         reg_rvalid,
    // Power request and power-on pins
    input  wire logic                    power_request,
    input  wire logic                    power_on_input,
    // Analogue status
    input  wire psc_pkg::psc_health_t    health,
    input  wire logic                    core_target_reached,
    input  wire logic                    battery_only,
    input  wire logic                    usb_cable_present,
    input  wire logic                    usb_int_source,
    input  wire logic                    usb_int_unmasked,
    input  wire logic                    master_clk_detected,
    // Regulator control
    output psc_pkg::psc_rail_t           rail_sleep,
    output logic      [3:0]              core_sleep_code,
    output logic                         card_reg_external,
    output logic                         twarn_masked,
    output psc_pkg::psc_clk_route_t      clk_route,
    // Pins
    output logic                         general_output_one_o,
    output logic                         general_output_one_oe_n,
    output logic                         general_output_two_o,
    output logic                         general_output_two_oe_n,
    output logic                         wake_interrupt_n_o,
    output logic                         wake_interrupt_n_oe_n,
    output logic                         usb_interrupt_n,
    output logic                         supplies_good
);

    // Byte lanes are fixed by the serial framing, so refuse other widths
    if (ADDR_W != 8 || DATA_W != 8) begin : g_width_check
        $error("psc_ctrl serves only 8-bit address and data");
    end

    // Register state
    logic [7:0]         pair_lo_q;
    logic [7:0]         pair_hi_q;
    logic [4:0]         sleep_allow_q;
    logic [4:0]         force_sleep_q;
    logic [7:0]         misc_cfg_q;
    logic [3:0]         core_code_q;
    logic               core_avail_q;
    logic               core_avail_d;
    logic [7:0]         rdata_q;
    logic               rvalid_q;

    // Pin state
    psc_pkg::psc_rail_t rail_q;
    psc_pkg::psc_rail_t rail_d;
    logic               req_q;
    logic               usb_unmask_q;
    logic               usb_int_n_q;
    logic               good_q;
    logic               wake_drive_q;

    // Decode
    wire                wr_lo;
    wire                wr_hi;
    wire                wr_cfg;
    wire                wr_core;
    wire                rd_core;
    wire [15:0]         pair_word;
    wire [4:0]          pair_idx;
    wire [7:0]          rd_mux;
    wire                usb_unmask_eff;
    wire                wake_req;
    wire                wake_masked;
    wire                hit_lo;
    wire                hit_hi;
    wire                hit_cfg;
    wire                hit_core;
    wire                cfg_twarn;
    wire                cfg_ext_card;
    wire                cfg_wake_mask;
    wire                cfg_general_output_one;
    wire                cfg_general_output_two;

    function automatic logic sleep_of(input logic allow,
                                      input logic force_bit,
                                      input logic request);
        sleep_of = force_bit | (allow & ~request);
    endfunction

    // One compare per address for the write strobes; only the core sleep hit also gates the read
    assign hit_lo    = (reg_addr == `PSC_ADDR_PAIR_LO);
    assign hit_hi    = (reg_addr == `PSC_ADDR_PAIR_HI);
    assign hit_cfg   = (reg_addr == `PSC_ADDR_MISC_CFG);
    assign hit_core  = (reg_addr == `PSC_ADDR_CORE_SLEEP);

    assign wr_lo     = reg_wr && hit_lo;
    assign wr_hi     = reg_wr && hit_hi;
    assign wr_cfg    = reg_wr && hit_cfg;
    assign wr_core   = reg_wr && hit_core;
    assign rd_core   = reg_rd && hit_core;

    // High byte write commits the word built with the last low byte
    assign pair_word = {reg_wdata, pair_lo_q};
    assign pair_idx  = pair_word[`PSC_IDX_MSB:`PSC_IDX_LSB];

    assign rd_mux =
        (reg_addr == `PSC_ADDR_PAIR_LO)    ? pair_lo_q :
        (reg_addr == `PSC_ADDR_PAIR_HI)    ? pair_hi_q :
        (reg_addr == `PSC_ADDR_MISC_CFG)   ?
            {3'b000, misc_cfg_q[`PSC_CFG_USED_W-1:0]} :
        (reg_addr == `PSC_ADDR_CORE_SLEEP) ?
            {3'b000, core_avail_q, core_code_q} :
        8'h00;

    // Raw bytes kept for readback; the low byte also builds the committed word
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pair_lo_q <= 8'h00;
        end else if (wr_lo) begin
            pair_lo_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pair_hi_q <= 8'h00;
        end else if (wr_hi) begin
            pair_hi_q <= reg_wdata;
        end
    end

    // Unknown index in a committed word is dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sleep_allow_q <= `PSC_RST_SLEEP_ALLOW;
            force_sleep_q <= `PSC_RST_FORCE_SLEEP;
        end else if (wr_hi) begin
            if (pair_idx == `PSC_IDX_SLEEP_ALLOW) begin
                sleep_allow_q <= pair_word[4:0];
            end
            if (pair_idx == `PSC_IDX_FORCE_SLEEP) begin
                force_sleep_q <= pair_word[4:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            misc_cfg_q <= `PSC_RST_MISC_CFG;
        end else if (wr_cfg) begin
            misc_cfg_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_code_q <= `PSC_RST_CORE_CODE;
        end else if (wr_core) begin
            core_code_q <= reg_wdata[3:0];
        end
    end

    // Set wins over the read clear so a late arrival is not lost
    assign core_avail_d = core_target_reached ? 1'b1 :
                          rd_core             ? 1'b0 :
                          core_avail_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_avail_q <= 1'b0;
        end else begin
            core_avail_q <= core_avail_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    // Data hold until the next read so a slow host can still take it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Rail modes
    always_comb begin
        rail_d.aux  = sleep_of(sleep_allow_q[`PSC_BIT_AUX],
                               force_sleep_q[`PSC_BIT_AUX],
                               power_request);
        rail_d.io   = sleep_of(sleep_allow_q[`PSC_BIT_IO],
                               force_sleep_q[`PSC_BIT_IO],
                               power_request);
        rail_d.core = sleep_of(sleep_allow_q[`PSC_BIT_CORE],
                               force_sleep_q[`PSC_BIT_CORE],
                               power_request);
    end

    // Unmask state frozen at the falling request edge
    assign usb_unmask_eff = req_q ? usb_int_unmasked : usb_unmask_q;

    assign wake_req    = battery_only & usb_cable_present;
    assign wake_masked = cfg_wake_mask & power_on_input;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rail_q <= '0;
        end else begin
            rail_q <= rail_d;
        end
    end

    // Idle level is high power, so no false request edge after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_q <= 1'b1;
        end else begin
            req_q <= power_request;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            usb_unmask_q <= 1'b0;
        end else begin
            usb_unmask_q <= usb_unmask_eff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            usb_int_n_q <= 1'b1;
        end else begin
            usb_int_n_q <= ~(usb_int_source & usb_unmask_eff);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            good_q <= 1'b0;
        end else begin
            good_q <= health.core_ok & health.io_ok &
                      ~health.over_temp & power_request;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_drive_q <= 1'b0;
        end else begin
            wake_drive_q <= wake_req & ~wake_masked;
        end
    end

    assign rail_sleep      = rail_q;
    assign core_sleep_code = core_code_q;
    assign usb_interrupt_n = usb_int_n_q;
    assign supplies_good   = good_q;

    // Named fields of the configuration byte
    assign cfg_twarn     = misc_cfg_q[`PSC_CFG_MASK_TWARN];
    assign cfg_ext_card  = misc_cfg_q[`PSC_CFG_EXT_CARD];
    assign cfg_wake_mask = misc_cfg_q[`PSC_CFG_WAKE_MASK];
    assign cfg_general_output_one      = misc_cfg_q[`PSC_CFG_GENERAL_OUTPUT_ONE];
    assign cfg_general_output_two      = misc_cfg_q[`PSC_CFG_GENERAL_OUTPUT_TWO];

    assign card_reg_external = cfg_ext_card;
    assign twarn_masked      = cfg_twarn;

    // Open drain: level stays 0, enable low pulls the pin
    assign general_output_one_o    = 1'b0;
    assign general_output_one_oe_n = cfg_general_output_one;
    assign general_output_two_o    = 1'b0;
    assign general_output_two_oe_n = cfg_general_output_two;
    assign wake_interrupt_n_o      = 1'b0;
    assign wake_interrupt_n_oe_n   = ~wake_drive_q;

    psc_clk_sel u_clk_sel (
        .clk                 (clk),
        .rst_b               (rst_b),
        .master_clk_detected (master_clk_detected),
        .high_power_mode     (power_request),
        .power_on_input      (power_on_input),
        .clk_route           (clk_route)
    );

endmodule // psc_ctrl

// ==== hw/psc_defs.svh ====
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

`define PSC_ADDR_PAIR_LO      8'h1E
`define PSC_ADDR_PAIR_HI      8'h1F
`define PSC_ADDR_MISC_CFG     8'h20
`define PSC_ADDR_CORE_SLEEP   8'h21

`define PSC_IDX_SLEEP_ALLOW   5'h09
`define PSC_IDX_FORCE_SLEEP   5'h0A
`define PSC_IDX_MSB           9
`define PSC_IDX_LSB           5

`define PSC_BIT_AUX           4
`define PSC_BIT_IO            2
`define PSC_BIT_CORE          1

`define PSC_RST_SLEEP_ALLOW   5'h16
`define PSC_RST_FORCE_SLEEP   5'h00
`define PSC_RST_MISC_CFG      8'h00
`define PSC_RST_CORE_CODE     4'h7

`define PSC_CFG_MASK_TWARN    0
`define PSC_CFG_EXT_CARD      1
`define PSC_CFG_WAKE_MASK     2
`define PSC_CFG_GENERAL_OUTPUT_ONE          3
`define PSC_CFG_GENERAL_OUTPUT_TWO          4
`define PSC_CFG_USED_W        5

`define PSC_CORE_AVAIL_BIT    4

`endif

// ==== hw/psc_pkg.sv ====
package psc_pkg;

    typedef struct packed {
        logic aux;
        logic io;
        logic core;
    } psc_rail_t;

    typedef struct packed {
        logic charge_pump;
        logic io_conv;
        logic core_conv;
    } psc_clk_route_t;

    typedef struct packed {
        logic core_ok;
        logic io_ok;
        logic over_temp;
    } psc_health_t;

    typedef enum logic [2:0] {
        PSC_CLK_INT    = 3'b001,
        PSC_CLK_MASTER = 3'b010,
        PSC_CLK_WAIT   = 3'b100
    } psc_clk_state_t;

endpackage

// ==== hw/psc_clk_sel.sv ====
`timescale 1ns/1ps
module psc_clk_sel (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    master_clk_detected,
    input  wire logic                    high_power_mode,
    input  wire logic                    power_on_input,
    output psc_pkg::psc_clk_route_t      clk_route
);
    psc_pkg::psc_clk_state_t state_q;
    psc_pkg::psc_clk_state_t state_d;
    psc_pkg::psc_clk_route_t route_q;
    logic                    use_master;

    // Master use is sticky in full power; only power-on low releases it
    always_comb begin
        state_d = state_q;
        case (state_q)
            psc_pkg::PSC_CLK_INT: begin
                if (master_clk_detected) begin
                    state_d = psc_pkg::PSC_CLK_MASTER;
                end
            end
            psc_pkg::PSC_CLK_MASTER: begin
                if (!power_on_input) begin
                    state_d = psc_pkg::PSC_CLK_WAIT;
                end else if (!master_clk_detected && !high_power_mode) begin
                    state_d = psc_pkg::PSC_CLK_INT;
                end
            end
            psc_pkg::PSC_CLK_WAIT: begin
                if (power_on_input) begin
                    state_d = psc_pkg::PSC_CLK_INT;
                end
            end
            default: begin
                state_d = psc_pkg::PSC_CLK_INT;
            end
        endcase
    end

    assign use_master = (state_d == psc_pkg::PSC_CLK_MASTER);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= psc_pkg::PSC_CLK_INT;
            route_q <= '0;
        end else begin
            state_q <= state_d;
            route_q <= {3{use_master}};
        end
    end

    assign clk_route = route_q;
endmodule // psc_clk_sel

// ==== tb/psc_ctrl_asserts.sv ====
`timescale 1ns/1ps
module psc_ctrl_asserts (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [7:0]              reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    reg_rvalid,
    input wire logic                    power_request,
    input wire logic                    power_on_input,
    input wire psc_pkg::psc_health_t    health,
    input wire logic                    core_target_reached,
    input wire logic                    battery_only,
    input wire logic                    usb_cable_present,
    input wire logic                    usb_int_source,
    input wire logic                    master_clk_detected,
    input wire psc_pkg::psc_rail_t      rail_sleep,
    input wire logic [3:0]              core_sleep_code,
    input wire logic                    card_reg_external,
    input wire psc_pkg::psc_clk_route_t clk_route,
    input wire logic                    general_output_one_oe_n,
    input wire logic                    general_output_two_oe_n,
    input wire logic                    wake_interrupt_n_oe_n,
    input wire logic                    usb_interrupt_n,
    input wire logic                    supplies_good
);
    // Shadow of the low byte, config byte and both sleep words, rebuilt from the bus alone
    logic [7:0] lo_q;
    logic [7:0] cfg_q;
    logic [4:0] alw_q;
    logic [4:0] frc_q;
    wire  [4:0] idx_w = {reg_wdata[1:0], lo_q[7:5]};
    wire  [2:0] slp_w = {frc_q[4], frc_q[2], frc_q[1]}
                      | ({alw_q[4], alw_q[2], alw_q[1]} & {3{~power_request}});
    wire        core_rd_w = reg_rd && reg_addr == 8'h21;
    logic       avl_q;

    // Reached flag as the rules give it: a set beats a read clear
    always_ff @(posedge clk) begin
        if (!rst_b) avl_q <= 1'b0;
        else avl_q <= core_target_reached | (avl_q & ~core_rd_w);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lo_q  <= 8'h00;
            cfg_q <= 8'h00;
            alw_q <= 5'h16;
            frc_q <= 5'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h1E) lo_q <= reg_wdata;
            if (reg_addr == 8'h20) cfg_q <= reg_wdata;
            if (reg_addr == 8'h1F && idx_w == 5'h09) alw_q <= lo_q[4:0];
            if (reg_addr == 8'h1F && idx_w == 5'h0A) frc_q <= lo_q[4:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_core_rd;
        reg_rd && reg_addr == 8'h21;
    endsequence
    sequence s_rd_quiet;
        s_core_rd ##0 !avl_q;
    endsequence
    sequence s_rd_flag;
        s_core_rd ##0 avl_q;
    endsequence

    a_rail_mode: assert property ($past(rst_b) |-> rail_sleep == $past(slp_w))
        else $error("rail sleep state wrong");
    a_good_level: assert property ($past(rst_b) |-> supplies_good == $past(
        health.core_ok && health.io_ok && !health.over_temp && power_request))
        else $error("supplies good wrong");
    a_pair_readback: assert property (reg_rd && reg_addr == 8'h1E |=>
        reg_rvalid && reg_rdata == lo_q) else $error("pair readback wrong");
    a_core_read: assert property (s_core_rd |=> reg_rdata[3:0] == core_sleep_code)
        else $error("core code readback wrong");
    a_avail_set: assert property (s_rd_flag |=> reg_rdata[4])
        else $error("reached flag not set");
    a_avail_clear: assert property (s_rd_quiet |=> !reg_rdata[4])
        else $error("reached flag not cleared");
    a_cfg_outputs: assert property (reg_wr && reg_addr == 8'h20 |-> ##2
        (general_output_one_oe_n == cfg_q[3] && general_output_two_oe_n == cfg_q[4]
        && card_reg_external == cfg_q[1])) else $error("config outputs wrong");
    a_wake_level: assert property ($past(rst_b) |-> wake_interrupt_n_oe_n ==
        !$past(battery_only && usb_cable_present && !(cfg_q[2] && power_on_input)))
        else $error("wake output wrong");
    a_usb_quiet: assert property (!usb_int_source |=> usb_interrupt_n)
        else $error("usb interrupt without source");
    a_clk_pick: assert property ((power_on_input && master_clk_detected) [*4]
        |-> clk_route == 3'b111) else $error("master clock not selected");
    a_clk_hold: assert property (clk_route == 3'b111 && power_request
        && power_on_input |=> clk_route == 3'b111) else $error("master clock dropped");
endmodule // psc_ctrl_asserts

bind psc_ctrl psc_ctrl_asserts psc_ctrl_asserts_i (.clk, .rst_b, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .power_request, .power_on_input,
    .health, .core_target_reached, .battery_only, .usb_cable_present, .usb_int_source,
    .master_clk_detected, .rail_sleep, .core_sleep_code, .card_reg_external,
    .clk_route, .general_output_one_oe_n, .general_output_two_oe_n,
    .wake_interrupt_n_oe_n, .usb_interrupt_n, .supplies_good);

// ==== tb/psc_host_model.sv ====
`timescale 1ns/1ps
module psc_host_model (
    input wire logic        clk,
    input wire logic        reg_rvalid,
    input wire logic [7:0]  reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse, never a stale match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
        @(posedge clk); #1;
        reg_wr = 1'b0; reg_addr = ~a; reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'hxx;
        @(posedge clk); #1;
        reg_rd = 1'b1; reg_addr = a;
        @(posedge clk); #1;
        reg_rd = 1'b0; reg_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin ok = 1'b1; d = reg_rdata; end
            else begin @(posedge clk); #1; end
        end
    endtask
endmodule // psc_host_model

// ==== tb/tb_pmic_sleep_irq_clock_ctrl.sv ====
`timescale 1ns/1ps
module tb_pmic_sleep_irq_clock_ctrl;
    typedef struct packed {logic [4:0] alw, frc; logic req; logic [2:0] exp;} psc_row_t;
    logic clk, rst_b, reg_wr, reg_rd, reg_rvalid, power_request, power_on_input;
    logic core_target_reached, battery_only, usb_cable_present, usb_int_source;
    logic usb_int_unmasked, master_clk_detected, card_ext, go1, go1_oe_n, go2;
    logic go2_oe_n, wk, wk_oe_n, usb_n, good, tw;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0] code;
    psc_pkg::psc_health_t health;
    psc_pkg::psc_rail_t rail;
    psc_pkg::psc_clk_route_t route;
    int failures, compares;
    psc_row_t rows [8] = '{'{5'h16, 5'h00, 1'b0, 3'h7}, '{5'h16, 5'h00, 1'b1, 3'h0},
        '{5'h10, 5'h00, 1'b0, 3'h4}, '{5'h04, 5'h00, 1'b0, 3'h2},
        '{5'h02, 5'h00, 1'b0, 3'h1}, '{5'h00, 5'h02, 1'b1, 3'h1},
        '{5'h00, 5'h14, 1'b1, 3'h6}, '{5'h00, 5'h00, 1'b0, 3'h0}};

    psc_ctrl psc_ctrl_i (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .power_request(power_request),
        .power_on_input(power_on_input), .health(health),
        .core_target_reached(core_target_reached), .battery_only(battery_only),
        .usb_cable_present(usb_cable_present), .usb_int_source(usb_int_source),
        .usb_int_unmasked(usb_int_unmasked), .master_clk_detected(master_clk_detected),
        .rail_sleep(rail), .core_sleep_code(code), .card_reg_external(card_ext),
        .twarn_masked(tw), .clk_route(route), .general_output_one_o(go1),
        .general_output_one_oe_n(go1_oe_n), .general_output_two_o(go2),
        .general_output_two_oe_n(go2_oe_n), .wake_interrupt_n_o(wk),
        .wake_interrupt_n_oe_n(wk_oe_n), .usb_interrupt_n(usb_n), .supplies_good(good));
    psc_host_model psc_host_model_i (.clk(clk), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));

    always #2 clk = ~clk;

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic ok;
        psc_host_model_i.rd(a, v, ok);
        if (!ok) begin failures++; $display("Error rvalid expected 1 seen 0"); stop_test; end
    endtask
    // Low byte first; the high byte commits the word
    task automatic word(input logic [4:0] idx, input logic [4:0] f);
        psc_host_model_i.wr(8'h1E, {idx[2:0], f});
        psc_host_model_i.wr(8'h1F, {6'h00, idx[4:3]});
    endtask

    initial begin
        clk = 1'b0; rst_b = 1'b0; power_request = 1'b1; power_on_input = 1'b1;
        core_target_reached = 1'b0; battery_only = 1'b0; usb_cable_present = 1'b0;
        usb_int_source = 1'b0; usb_int_unmasked = 1'b0; health = 3'b110;
        master_clk_detected = 1'b0;
        failures = 0; compares = 0;
        cyc(3); rst_b = 1'b1;
        chk("rail", 8'h00, {5'h00, rail});
        chk("oe", 8'h00, {6'h00, go1_oe_n, go2_oe_n});
        chk("pins", 8'h00, {5'h00, go1, go2, wk});
        rd(8'h21, d); chk("core", 8'h07, d);
        $display("reset test done");
        foreach (rows[i]) begin
            word(5'h09, rows[i].alw); word(5'h0A, rows[i].frc);
            power_request = rows[i].req; cyc(2);
            chk("rail", {5'h00, rows[i].exp}, {5'h00, rail});
            chk("good", {7'h00, rows[i].req}, {7'h00, good});
        end
        $display("rail table test done");
        rd(8'h1E, d); chk("lo", 8'h40, d);
        rd(8'h1F, d); chk("hi", 8'h01, d);
        rd(8'h30, d); chk("gap", 8'h00, d);
        // Bit 4 is read only, so it must not follow the write
        psc_host_model_i.wr(8'h21, 8'h1A); rd(8'h21, d); chk("code", 8'h0A, d);
        chk("code_out", 8'h0A, {4'h0, code});
        core_target_reached = 1'b1; cyc(1); core_target_reached = 1'b0;
        rd(8'h21, d); chk("flag", 8'h1A, d);
        rd(8'h21, d); chk("clr", 8'h0A, d);
        psc_host_model_i.wr(8'h20, 8'h18); cyc(1);
        chk("hiz", 8'h03, {6'h00, go1_oe_n, go2_oe_n});
        psc_host_model_i.wr(8'h20, 8'h03); cyc(1);
        chk("low", 8'h0C, {4'h0, tw, card_ext, go1_oe_n, go2_oe_n});
        battery_only = 1'b1; usb_cable_present = 1'b1; cyc(2);
        chk("wake", 8'h00, {7'h00, wk_oe_n});
        psc_host_model_i.wr(8'h20, 8'h04); cyc(1);
        chk("mask", 8'h01, {7'h00, wk_oe_n});
        power_on_input = 1'b0; cyc(2); chk("mask", 8'h00, {7'h00, wk_oe_n});
        power_on_input = 1'b1; battery_only = 1'b0; cyc(2);
        $display("register test done");
        power_request = 1'b1; usb_int_unmasked = 1'b1; usb_int_source = 1'b1; cyc(2);
        chk("usb", 8'h00, {7'h00, usb_n});
        power_request = 1'b0; cyc(3); chk("usb", 8'h00, {7'h00, usb_n});
        power_request = 1'b1; usb_int_unmasked = 1'b0; cyc(2); power_request = 1'b0;
        // Unmask only after the request has fallen: it must not count
        cyc(1); usb_int_unmasked = 1'b1; cyc(3);
        chk("usb", 8'h01, {7'h00, usb_n});
        usb_int_source = 1'b0; power_request = 1'b1; health.over_temp = 1'b1; cyc(2);
        chk("heat", 8'h00, {7'h00, good});
        health = 3'b100; cyc(2); chk("io", 8'h00, {7'h00, good});
        health = 3'b110; cyc(2); chk("good", 8'h01, {7'h00, good});
        $display("interrupt test done");
        master_clk_detected = 1'b1; cyc(4);
        chk("clk", 8'h07, {5'h00, route});
        // Detection lost in high power mode must not switch away
        master_clk_detected = 1'b0; cyc(3); chk("hold", 8'h07, {5'h00, route});
        power_on_input = 1'b0; cyc(2); power_on_input = 1'b1; cyc(3);
        chk("int", 8'h00, {5'h00, route});
        rst_b = 1'b0; cyc(1); rst_b = 1'b1;
        rd(8'h21, d); chk("core", 8'h07, d);
        $display("clock and reset test done");
        stop_test;
    end
endmodule // tb_pmic_sleep_irq_clock_ctrl
